//--- bench/cpu_core_model.sv
// Purpose: cpu core stand-in driving the bus and the decode address
// Assumes: one request at a time, classic wishbone
// Notes:   released address and data lines show inverted data so stale values never pass; sel and we keep their values
`timescale 1ns/100ps
module cpu_core_model (
  input  wire logic        clk_in,
  input  wire logic        ack_in,
  input  wire logic [31:0] dat_in,
  output logic [7:0]       adr_out,
  output logic [31:0]      dat_out,
  output logic [3:0]       sel_out,
  output logic             we_out,
  output logic             cyc_out,
  output logic             stb_out,
  output logic [15:0]      addr_out,
  output logic             valid_out
);
  initial begin
    {adr_out, dat_out, sel_out, we_out, cyc_out, stb_out} = '0;
    {addr_out, valid_out} = '0;
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] rd, output int waits);
    waits = 0;
    @(posedge clk_in);
    cyc_out <= 1'b1;
    stb_out <= 1'b1;
    we_out  <= w;
    adr_out <= a;
    dat_out <= d;
    sel_out <= s;
    @(posedge clk_in);
    // no limit of its own: the bench watchdog ends a hung wait
    while (ack_in !== 1'b1) begin
      @(posedge clk_in);
      waits++;
    end
    rd = dat_in;
    cyc_out <= 1'b0;
    stb_out <= 1'b0;
    adr_out <= ~a;
    dat_out <= ~d;
  endtask
  task automatic look(input logic [15:0] a);
    @(posedge clk_in);
    addr_out  <= a;
    valid_out <= 1'b1;
    @(posedge clk_in);
    addr_out  <= ~a;
    valid_out <= 1'b0;
    #1;
  endtask
endmodule

//--- bench/tb_ram_register_block_remap.sv
// Purpose: self-checking bench for the map relocation block
// Assumes: cpu_core_model drives every design input but clock and reset
// Notes:   default and move tests run while the window is open; the window test waits for it to close
`timescale 1ns/100ps
module tb_ram_register_block_remap;
  logic        clk;
  logic        rst;
  logic [7:0]  adr;
  logic [31:0] dw;
  logic [31:0] dr;
  logic [3:0]  sel;
  logic        we;
  logic        cyc;
  logic        stb;
  logic        ack;
  logic [15:0] ca;
  logic        cv;
  logic        ms;
  logic [7:0]  ma;
  logic        cs;
  logic [5:0]  cadr;
  logic [7:0]  map;
  logic        win;
  int          n_mismatch;
  int          checks;
  int          since;
  cpu_core_model cpu_core_model_inst (.clk_in(clk), .ack_in(ack), .dat_in(dr), .adr_out(adr),
    .dat_out(dw), .sel_out(sel), .we_out(we), .cyc_out(cyc), .stb_out(stb), .addr_out(ca),
    .valid_out(cv));
  ram_register_block_remap #(.WINDOW_LEN(64)) ram_register_block_remap_inst (.CLK_IN(clk),
    .RST_IN(rst), .WB_ADR_IN(adr), .WB_DAT_IN(dw), .WB_SEL_IN(sel), .WB_WE_IN(we),
    .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_DAT_OUT(dr), .WB_ACK_OUT(ack), .CPU_ADDR_IN(ca),
    .CPU_VALID_IN(cv), .MEM_SEL_OUT(ms), .MEM_ADDR_OUT(ma), .CTL_SEL_OUT(cs),
    .CTL_ADDR_OUT(cadr), .MAP_OUT(map), .WINDOW_OPEN_OUT(win));
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic dec(input logic [15:0] a, input logic m, input logic c);
    cpu_core_model_inst.look(a);
    chk("mem sel", 32'(ms), 32'(m));
    chk("ctl sel", 32'(cs), 32'(c));
    if (c) chk("ctl addr", 32'(cadr), 32'(a[5:0]));
    if (m) chk("mem addr", 32'(ma), 32'(a[7:0]));
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [31:0] exp);
    logic [31:0] rd;
    int          waits;
    cpu_core_model_inst.wb(w, a, d, s, rd, waits);
    // let the ack edge settle so map updates are seen
    #1;
    chk("ack", 32'(waits), 32'h0000_0001);
    if (!w) chk("read data", rd, exp);
  endtask
  task automatic test_defaults;
    chk("map", 32'(map), 32'h0000_0001);
    acc(1'b0, 8'h00, 32'h0000_0000, 4'h1, 32'h0000_0001);
    dec(16'h1005, 1'b0, 1'b1);
    dec(16'h103F, 1'b0, 1'b1);
    dec(16'h1040, 1'b0, 1'b0);
    dec(16'h00FF, 1'b1, 1'b0);
    dec(16'h0100, 1'b0, 1'b0);
    $display("test defaults done");
  endtask
  task automatic test_move;
    acc(1'b1, 8'h00, 32'h0000_0052, 4'h2, 32'h0000_0000);
    chk("map", 32'(map), 32'h0000_0001);
    acc(1'b1, 8'h00, 32'h0000_0031, 4'h1, 32'h0000_0000);
    dec(16'h3010, 1'b1, 1'b0);
    dec(16'h1010, 1'b0, 1'b1);
    acc(1'b1, 8'h00, 32'h0000_0052, 4'h1, 32'h0000_0000);
    dec(16'h5080, 1'b1, 1'b0);
    dec(16'h203F, 1'b0, 1'b1);
    acc(1'b1, 8'h00, 32'h0000_0053, 4'h1, 32'h0000_0000);
    dec(16'h3000, 1'b0, 1'b1);
    $display("test move done");
  endtask
  task automatic test_window;
    int n;
    n = 0;
    while (win !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk("window", 32'(n < 100), 32'h0000_0001);
    acc(1'b1, 8'h00, 32'h0000_0077, 4'h1, 32'h0000_0000);
    dec(16'h5000, 1'b1, 1'b0);
    acc(1'b0, 8'h04, 32'h0000_0000, 4'hF, 32'h0000_0002);
    acc(1'b0, 8'h08, 32'h0000_0000, 4'hF, 32'h0000_0000);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("map", 32'(map), 32'h0000_0001);
    chk("window", 32'(win), 32'h0000_0001);
    acc(1'b1, 8'h00, 32'h0000_0023, 4'h1, 32'h0000_0000);
    dec(16'h2001, 1'b1, 1'b0);
    while (win !== 1'b0) @(posedge clk);
    chk("window length", 32'(since), 32'h0000_0040);
    $display("test window done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // edges since the last reset release
  always @(posedge clk) begin
    since <= rst ? 0 : since + 1;
  end
  initial begin
    repeat (1000) @(posedge clk);
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    test_defaults;
    test_move;
    test_window;
    report_and_stop;
  end
endmodule

//--- hdl/ram_register_block_remap.sv
// Purpose: places the 64-byte control block and 256-byte ram in cpu space
// Assumes: cpu address and wishbone inputs synchronous to CLK_IN
// Notes:   decode outputs lag the cpu address by one clock
//
// How it works
// - control block decodes 64 bytes 00-3f, top address digit set by software
// - after reset ram sits at 0000-00ff
// - after reset the control block sits at 1000-103f
// - map register writable only in first 64 clock cycles after reset
// - ram and control block can be moved alone or together
//
// The Wishbone slave port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "remap_regs.svh"

module ram_register_block_remap
  import remap_pkg::*;
#(
  parameter int WINDOW_LEN = `WINDOW_CYCLES
) (
  input  wire logic        CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic [7:0]  WB_ADR_IN,
  input  wire logic [31:0] WB_DAT_IN,
  input  wire logic [3:0]  WB_SEL_IN,
  input  wire logic        WB_WE_IN,
  input  wire logic        WB_CYC_IN,
  input  wire logic        WB_STB_IN,
  output logic [31:0]      WB_DAT_OUT,
  output logic             WB_ACK_OUT,
  input  wire logic [15:0] CPU_ADDR_IN,
  input  wire logic        CPU_VALID_IN,
  output logic             MEM_SEL_OUT,
  output logic [7:0]       MEM_ADDR_OUT,
  output logic             CTL_SEL_OUT,
  output logic [5:0]       CTL_ADDR_OUT,
  output logic [7:0]       MAP_OUT,
  output logic             WINDOW_OPEN_OUT
);

  localparam int CW = $clog2(WINDOW_LEN + 1);

  // page hit: top digit matches and the bits between the digit and the block are zero
  function automatic logic ctl_hit(
    input logic [15:0] addr,
    input logic [3:0]  page
  );
    ctl_hit = (addr[15:12] == page) && (addr[11:6] == 6'h00);
  endfunction

  function automatic logic mem_hit(
    input logic [15:0] addr,
    input logic [3:0]  page
  );
    mem_hit = (addr[15:12] == page) && (addr[11:8] == 4'h0);
  endfunction

  // write window

  window_state_t   win;
  window_state_t   next_win;
  logic [CW-1:0]   cycles;
  logic [CW-1:0]   next_cycles;

  always_comb begin
    next_win    = win;
    next_cycles = cycles;
    case (win)
      WIN_OPEN: begin
        next_cycles = cycles + CW'(1);
        if (next_cycles == CW'(WINDOW_LEN)) begin
          next_win = WIN_SHUT;
        end
      end
      WIN_SHUT: begin
        next_cycles = cycles;
      end
      default: begin
        next_win = WIN_SHUT;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      win    <= WIN_OPEN;
      cycles <= '0;
    end else begin
      win    <= next_win;
      cycles <= next_cycles;
    end
  end

  // wishbone slave and mapping register

  logic [7:0]  map;
  logic [7:0]  next_map;
  logic        written;
  logic        next_written;
  logic        ack;
  logic        next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        wr_take;

  // write lands on the edge where the master sees ack
  assign wr_take = WB_CYC_IN && WB_STB_IN && WB_WE_IN && ack;

  always_comb begin
    next_map     = map;
    next_written = written;
    next_rdata   = rdata;
    next_ack     = WB_CYC_IN && WB_STB_IN && !ack;
    if (next_ack && !WB_WE_IN) begin
      case (WB_ADR_IN)
        `MAP_OFFSET: begin
          next_rdata = {24'h00_0000, map};
        end
        `STATUS_OFFSET: begin
          next_rdata = 32'h0000_0000;
          next_rdata[`STAT_OPEN_BIT]    = (win == WIN_OPEN);
          next_rdata[`STAT_WRITTEN_BIT] = written;
        end
        default: begin
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
    // a late write is acked but dropped: the map is frozen
    if (wr_take && WB_ADR_IN == `MAP_OFFSET
        && WB_SEL_IN[0] && win == WIN_OPEN) begin
      // one write may move either page or both
      next_map     = WB_DAT_IN[7:0];
      next_written = 1'b1;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      map     <= `MAP_RESET;
      written <= 1'b0;
      ack     <= 1'b0;
      rdata   <= 32'h0000_0000;
    end else begin
      map     <= next_map;
      written <= next_written;
      ack     <= next_ack;
      rdata   <= next_rdata;
    end
  end

  assign WB_ACK_OUT = ack;
  assign WB_DAT_OUT = rdata;
  assign MAP_OUT    = map;

  // cpu address decode

  logic [3:0] mem_page;
  logic [3:0] ctl_page;
  decode_t    dec;
  decode_t    next_dec;
  logic       open_q;
  logic       next_open_q;

  assign mem_page = map[`MEM_DIGIT_MSB:`MEM_DIGIT_LSB];
  assign ctl_page = map[`CTL_DIGIT_MSB:`CTL_DIGIT_LSB];

  always_comb begin
    next_dec          = '0;
    next_open_q       = (next_win == WIN_OPEN);
    next_dec.mem_addr = CPU_ADDR_IN[7:0];
    next_dec.ctl_addr = CPU_ADDR_IN[5:0];
    if (CPU_VALID_IN) begin
      // registers overlay ram when both share one page
      if (ctl_hit(CPU_ADDR_IN, ctl_page)) begin
        next_dec.ctl_sel = 1'b1;
      end else if (mem_hit(CPU_ADDR_IN, mem_page)) begin
        next_dec.mem_sel = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      dec    <= '0;
      open_q <= 1'b1;
    end else begin
      dec    <= next_dec;
      open_q <= next_open_q;
    end
  end

  assign MEM_SEL_OUT     = dec.mem_sel;
  assign MEM_ADDR_OUT    = dec.mem_addr;
  assign CTL_SEL_OUT     = dec.ctl_sel;
  assign CTL_ADDR_OUT    = dec.ctl_addr;
  assign WINDOW_OPEN_OUT = open_q;

  // checks

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);

  ctl_decode_a: assert property (
    CPU_VALID_IN && CPU_ADDR_IN[15:12] == map[3:0]
      && CPU_ADDR_IN[11:6] == 6'h00
    |=> CTL_SEL_OUT && !MEM_SEL_OUT
        && CTL_ADDR_OUT == $past(CPU_ADDR_IN[5:0])
  ) else $error("control block not decoded");

  ctl_span_a: assert property (
    CPU_VALID_IN && CPU_ADDR_IN[11:6] != 6'h00
    |=> !CTL_SEL_OUT
  ) else $error("control block decoded beyond 64 bytes");

  mem_decode_a: assert property (
    CPU_VALID_IN && CPU_ADDR_IN[15:12] == map[7:4]
      && CPU_ADDR_IN[11:8] == 4'h0
      && !(CPU_ADDR_IN[15:12] == map[3:0]
           && CPU_ADDR_IN[11:6] == 6'h00)
    |=> MEM_SEL_OUT && MEM_ADDR_OUT == $past(CPU_ADDR_IN[7:0])
  ) else $error("ram not decoded");

  default_map_a: assert property (
    !written |-> map == `MAP_RESET
  ) else $error("map left default without a write");

  window_len_a: assert property (
    cycles < CW'(WINDOW_LEN) |-> win == WIN_OPEN
  ) else $error("window shut early");

  window_shut_a: assert property (
    win == WIN_OPEN ##1 win == WIN_SHUT
    |-> cycles == CW'(WINDOW_LEN)
  ) else $error("window shut at wrong count");

  map_frozen_a: assert property (
    win == WIN_SHUT |=> $stable(map)
  ) else $error("map changed after window");

  map_write_a: assert property (
    wr_take && WB_ADR_IN == `MAP_OFFSET && WB_SEL_IN[0]
      && win == WIN_OPEN
    |=> map == $past(WB_DAT_IN[7:0])
  ) else $error("map write lost");

  page_split_a: assert property (
    map[7:4] != map[3:0] && CPU_VALID_IN
      && CPU_ADDR_IN == {map[7:4], 12'h000}
    |=> MEM_SEL_OUT && !CTL_SEL_OUT
  ) else $error("ram page digit misplaced");

  ack_pulse_a: assert property (
    WB_ACK_OUT |=> !WB_ACK_OUT
  ) else $error("ack held two cycles");

  ack_answer_a: assert property (
    WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT
  ) else $error("ack late");

  open_flag_a: assert property (
    WINDOW_OPEN_OUT == (win == WIN_OPEN)
  ) else $error("window flag disagrees with window state");

  late_write_a: assert property (
    wr_take && win == WIN_SHUT
    |=> map == $past(map)
  ) else $error("map write landed after window");

  window_cap_a: assert property (
    cycles <= CW'(WINDOW_LEN)
  ) else $error("window counter ran past its end");

  status_read_a: assert property (
    WB_CYC_IN && WB_STB_IN && !WB_WE_IN && !WB_ACK_OUT
      && WB_ADR_IN == `STATUS_OFFSET
    |=> WB_DAT_OUT[`STAT_OPEN_BIT] == $past(win == WIN_OPEN)
  ) else $error("status window bit wrong");

  mem_span_a: assert property (
    CPU_VALID_IN && CPU_ADDR_IN[11:8] != 4'h0
    |=> !MEM_SEL_OUT
  ) else $error("ram decoded beyond 256 bytes");

  mem_default_a: assert property (
    !written && CPU_VALID_IN && CPU_ADDR_IN[15:8] == 8'h00
    |=> MEM_SEL_OUT
  ) else $error("ram not at its reset page");

  ctl_default_a: assert property (
    !written && CPU_VALID_IN && CPU_ADDR_IN[15:6] == 10'h040
    |=> CTL_SEL_OUT
  ) else $error("control block not at its reset page");

  idle_decode_a: assert property (
    !CPU_VALID_IN
    |=> !MEM_SEL_OUT && !CTL_SEL_OUT
  ) else $error("select raised without a valid address");

  one_select_a: assert property (
    !(MEM_SEL_OUT && CTL_SEL_OUT)
  ) else $error("ram and control block selected together");

  map_read_a: assert property (
    WB_CYC_IN && WB_STB_IN && !WB_WE_IN && !WB_ACK_OUT
      && WB_ADR_IN == `MAP_OFFSET
    |=> WB_DAT_OUT == {24'h00_0000, $past(map)}
  ) else $error("map read back wrong");

endmodule

//--- hdl/remap_pkg.sv
// Purpose: types shared by the map relocation block
// Assumes: remap_regs.svh holds the numbers
// Notes:   decode results travel as one packed struct
package remap_pkg;

  typedef enum logic {
    WIN_OPEN,
    WIN_SHUT
  } window_state_t;

  typedef struct packed {
    logic       mem_sel;
    logic [7:0] mem_addr;
    logic       ctl_sel;
    logic [5:0] ctl_addr;
  } decode_t;

endpackage

//--- hdl/remap_regs.svh
// Purpose: offsets, fields, reset values and counts of the map relocation block
// Assumes: 32-bit wishbone data, byte addresses
// Notes:   definitions only
`ifndef REMAP_REGS_SVH
`define REMAP_REGS_SVH

// register byte offsets
`define MAP_OFFSET        8'h00
`define STATUS_OFFSET     8'h04

// mapping register fields
`define MEM_DIGIT_MSB     7
`define MEM_DIGIT_LSB     4
`define CTL_DIGIT_MSB     3
`define CTL_DIGIT_LSB     0

// default pages after reset: ram at 0000-00ff, registers at 1000-103f
`define MEM_PAGE_RESET    4'h0
`define CTL_PAGE_RESET    4'h1
`define MAP_RESET         8'h01

// status bits
`define STAT_OPEN_BIT     0
`define STAT_WRITTEN_BIT  1

// write window length in clock cycles
`define WINDOW_CYCLES     64

// block sizes inside a page
`define CTL_LAST_LOW      8'h3f
`define MEM_LAST_LOW      16'h00ff

`endif
